// >>> fcs_flash_ctrl.sv
// Flash controller control side: array read gate, clock divider, security options, key gate.
// Assumes array macro, key comparator and command sequencer all run on clk.
`timescale 1ns/10ps

module fcs_flash_ctrl
  import fcs_pkg::*;
#(
  parameter int unsigned PAGES = 256,
  parameter int unsigned PAGE_BYTES = 512,
  parameter int unsigned BLOCKS = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire fcs_wb_req_t wb_req,
  output logic wb_ack_ff,
  output logic [31:0] wb_dat_ff,
  input wire fcs_arr_req_t arr_req,
  input wire logic [7:0] cell_data,
  input wire logic [BLOCKS-1:0] cmd_busy,
  input wire logic [7:0] nonvolatile_security_byte,
  input wire logic key_match,
  input wire logic pe_start,
  output logic [7:0] rd_data_ff,
  output logic rd_valid_ff,
  output logic rd_blocked_ff,
  output logic cmd_write_ff,
  output logic key_write_ff,
  output logic [16:0] wr_addr_ff,
  output logic [7:0] wr_data_ff,
  output logic [$clog2(PAGES)-1:0] wr_page_ff,
  output logic divided_flash_clock_ff,
  output logic pe_pulse_ff,
  output logic secured_ff
);

  localparam int unsigned ADDR_W = $clog2(PAGES * PAGE_BYTES);
  localparam int unsigned PAGE_W = $clog2(PAGES);
  localparam int unsigned BLK_W = (BLOCKS > 1) ? $clog2(BLOCKS) : 1;
  localparam int unsigned REG_IDX_W = $clog2(FCS_REG_COUNT);

  // ---------------- Register bus decode ----------------
  logic bus_req_w;
  logic bus_wr_w;
  logic bus_in_map_w;
  logic hit_clkdiv_w;
  logic hit_secopt_w;
  logic hit_keycfg_w;
  logic hit_status_w;
  logic wr_clkdiv_w;
  logic wr_keycfg_w;

  assign bus_req_w = wb_req.cyc && wb_req.stb && !wb_ack_ff;
  assign bus_wr_w = bus_req_w && wb_req.we && wb_req.sel[0];
  // Sixteen words; addresses beyond them answer with zero
  assign bus_in_map_w = (wb_req.adr[FCS_ADR_W-1:2] < 6'(FCS_REG_COUNT));
  assign hit_clkdiv_w = bus_in_map_w && (wb_req.adr[FCS_ADR_W-1:2] == FCS_OFS_CLKDIV[7:2]);
  assign hit_secopt_w = bus_in_map_w && (wb_req.adr[FCS_ADR_W-1:2] == FCS_OFS_SECOPT[7:2]);
  assign hit_keycfg_w = bus_in_map_w && (wb_req.adr[FCS_ADR_W-1:2] == FCS_OFS_KEYCFG[7:2]);
  assign hit_status_w = bus_in_map_w && (wb_req.adr[FCS_ADR_W-1:2] == FCS_OFS_STATUS[7:2]);
  assign wr_clkdiv_w = bus_wr_w && hit_clkdiv_w;
  assign wr_keycfg_w = bus_wr_w && hit_keycfg_w;

  // ---------------- Clock divider register ----------------
  logic div_written_ff;
  logic div_locked_ff;
  logic prescale_bit_ff;
  logic [FCS_DIV_W-1:0] divider_field_ff;
  logic div_accept_w;

  assign div_accept_w = wr_clkdiv_w && !div_locked_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_written_ff <= FCS_CLKDIV_RST[FCS_DIVLD_BIT];
      div_locked_ff <= 1'b0;
      prescale_bit_ff <= FCS_CLKDIV_RST[FCS_PRESCALE_BIT];
      divider_field_ff <= FCS_CLKDIV_RST[FCS_DIV_W-1:0];
    end else if (div_accept_w) begin
      div_written_ff <= 1'b1;
      div_locked_ff <= !wb_req.dat[FCS_DIVLD_BIT];
      prescale_bit_ff <= wb_req.dat[FCS_PRESCALE_BIT];
      divider_field_ff <= wb_req.dat[FCS_DIV_W-1:0];
    end
  end

  // ---------------- Divided flash clock ----------------
  logic [FCS_PRE_W-1:0] pre_cnt_ff;
  logic [FCS_DIV_W-1:0] div_cnt_ff;
  logic pre_tick_w;
  logic flash_tick_w;
  logic [9:0] ratio_w;
  logic range_ok_w;

  assign pre_tick_w = !prescale_bit_ff || (pre_cnt_ff == 3'(FCS_PRESCALE_RATIO - 1));
  assign flash_tick_w = pre_tick_w && (div_cnt_ff == divider_field_ff);
  assign ratio_w = prescale_bit_ff ? {1'b0, ({3'h0, divider_field_ff} + 9'h001)} << 3
                                   : {3'h0, divider_field_ff} + 10'h001;
  // Period in bus cycles checked against the pulse window
  assign range_ok_w = (32'(ratio_w) >= FCS_PULSE_MIN_CYC) && (32'(ratio_w) <= FCS_PULSE_MAX_CYC);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_cnt_ff <= 3'h0;
      div_cnt_ff <= 6'h00;
      divided_flash_clock_ff <= 1'b0;
    end else if (div_accept_w) begin
      // Restart the divider cleanly on a new setting
      pre_cnt_ff <= 3'h0;
      div_cnt_ff <= 6'h00;
      divided_flash_clock_ff <= 1'b0;
    end else begin
      pre_cnt_ff <= prescale_bit_ff ? pre_cnt_ff + 3'h1 : 3'h0;
      if (pre_tick_w) begin
        div_cnt_ff <= flash_tick_w ? 6'h00 : div_cnt_ff + 6'h01;
      end
      divided_flash_clock_ff <= flash_tick_w;
    end
  end

  // ---------------- Program/erase timing pulse ----------------
  fcs_pulse_state_t ps_ff;
  fcs_pulse_state_t nxt_ps;

  always_comb begin
    nxt_ps = ps_ff;
    unique case (ps_ff)
      FCS_PS_IDLE: if (pe_start) nxt_ps = FCS_PS_ARM;
      FCS_PS_ARM: if (flash_tick_w) nxt_ps = FCS_PS_ACTIVE;
      FCS_PS_ACTIVE: if (flash_tick_w) nxt_ps = FCS_PS_IDLE;
      default: nxt_ps = FCS_PS_IDLE;
    endcase
    if (div_accept_w) nxt_ps = FCS_PS_IDLE;
  end

  // One full flash clock period, aligned to its ticks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ps_ff <= FCS_PS_IDLE;
      pe_pulse_ff <= 1'b0;
    end else begin
      ps_ff <= nxt_ps;
      pe_pulse_ff <= (nxt_ps == FCS_PS_ACTIVE);
    end
  end

  // ---------------- Security options ----------------
  logic opt_loaded_ff;
  logic [7:0] secopt_ff;
  logic key_enabled_w;
  logic unsecured_w;

  assign key_enabled_w = (secopt_ff[FCS_KEY_ENABLE_LO +: 2] == FCS_KEY_ENABLE_ON);
  assign unsecured_w = (secopt_ff[FCS_SECURITY_LO +: 2] == FCS_SECURITY_OPEN);

  // Captured on the first edge after reset release, never from the bus
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      opt_loaded_ff <= 1'b0;
      secopt_ff <= FCS_SECOPT_RST;
    end else if (!opt_loaded_ff) begin
      opt_loaded_ff <= 1'b1;
      secopt_ff <= nonvolatile_security_byte;
    end else if (key_match && key_enabled_w) begin
      secopt_ff[FCS_SECURITY_LO +: 2] <= FCS_SECURITY_OPEN;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      secured_ff <= 1'b1;
    end else begin
      secured_ff <= !opt_loaded_ff || !unsecured_w;
    end
  end

  // ---------------- Key configuration ----------------
  logic key_access_bit_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      key_access_bit_ff <= FCS_KEYCFG_RST[FCS_KEY_ACCESS_BIT];
    end else if (wr_keycfg_w && key_enabled_w) begin
      key_access_bit_ff <= wb_req.dat[FCS_KEY_ACCESS_BIT];
    end
  end

  // ---------------- Register read mux and answer ----------------
  logic [7:0] rd_clkdiv_w;
  logic [7:0] rd_keycfg_w;
  logic [7:0] rd_status_w;
  logic [7:0] rd_mux_w;

  assign rd_clkdiv_w = {div_written_ff, prescale_bit_ff, divider_field_ff};
  assign rd_keycfg_w = 8'(key_access_bit_ff) << FCS_KEY_ACCESS_BIT;
  assign rd_status_w = {4'h0, pe_pulse_ff, range_ok_w, key_enabled_w, secured_ff};
  assign rd_mux_w = hit_clkdiv_w ? rd_clkdiv_w :
                    hit_secopt_w ? secopt_ff :
                    hit_keycfg_w ? rd_keycfg_w :
                    hit_status_w ? rd_status_w : 8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_ff <= 1'b0;
      wb_dat_ff <= 32'h0000_0000;
    end else begin
      wb_ack_ff <= bus_req_w;
      wb_dat_ff <= (bus_req_w && !wb_req.we) ? {24'h00_0000, rd_mux_w} : 32'h0000_0000;
    end
  end

  // ---------------- Array read and write routing ----------------
  logic [BLK_W-1:0] rd_blk_w;
  logic rd_block_busy_w;
  logic rd_ok_w;

  assign rd_blk_w = (BLOCKS > 1) ? arr_req.addr[ADDR_W-1 -: BLK_W] : '0;
  assign rd_block_busy_w = cmd_busy[rd_blk_w];
  // Key access does not gate reads
  assign rd_ok_w = arr_req.rd && !rd_block_busy_w;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_ff <= 8'hFF;
      rd_valid_ff <= 1'b0;
      rd_blocked_ff <= 1'b0;
    end else begin
      rd_valid_ff <= rd_ok_w;
      rd_blocked_ff <= arr_req.rd && rd_block_busy_w;
      if (rd_ok_w) begin
        // Cell reports charge: programmed cell is 1, so invert
        rd_data_ff <= ~cell_data;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_write_ff <= 1'b0;
      key_write_ff <= 1'b0;
      wr_addr_ff <= 17'h0_0000;
      wr_data_ff <= 8'h00;
      wr_page_ff <= '0;
    end else begin
      cmd_write_ff <= arr_req.wr && !key_access_bit_ff;
      key_write_ff <= arr_req.wr && key_access_bit_ff;
      if (arr_req.wr) begin
        wr_addr_ff <= arr_req.addr;
        wr_data_ff <= arr_req.wdata;
        wr_page_ff <= arr_req.addr[ADDR_W-1 -: PAGE_W];
      end
    end
  end

  // ---------------- Checks ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [9:0] gap_ff;
  logic seen_tick_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_ff <= 10'h000;
      seen_tick_ff <= 1'b0;
    end else if (div_accept_w) begin
      gap_ff <= 10'h000;
      seen_tick_ff <= 1'b0;
    end else begin
      gap_ff <= divided_flash_clock_ff ? 10'h001 : gap_ff + 10'h001;
      if (divided_flash_clock_ff) seen_tick_ff <= 1'b1;
    end
  end

  a_rd_one_cycle: assert property (rd_ok_w |=> rd_valid_ff && !rd_blocked_ff)
    else $error("read not answered in one cycle");
  a_rd_polarity: assert property (rd_ok_w |=> rd_data_ff == ~$past(cell_data))
    else $error("read data polarity wrong");
  a_rd_busy_block: assert property (arr_req.rd && rd_block_busy_w |=> rd_blocked_ff && !rd_valid_ff)
    else $error("read of busy block served");
  a_div_lock_hold: assert property (div_locked_ff |=> $stable(rd_clkdiv_w))
    else $error("locked divider changed");
  a_divld_read: assert property (wb_ack_ff && !$past(wb_req.we) && $past(hit_clkdiv_w)
    |-> wb_dat_ff[FCS_DIVLD_BIT] == div_written_ff)
    else $error("load bit reads wrong");
  a_divided_flash_clock_period: assert property (divided_flash_clock_ff && seen_tick_ff && !div_accept_w
    |-> gap_ff == ratio_w)
    else $error("flash clock period wrong");
  a_pulse_edges: assert property ($rose(pe_pulse_ff) |-> divided_flash_clock_ff
    ##1 (pe_pulse_ff [*1] ##1 1'b1))
    else $error("pulse not aligned to flash clock");
  a_pulse_fall: assert property ($fell(pe_pulse_ff) |-> divided_flash_clock_ff)
    else $error("pulse did not end on a flash clock tick");
  a_secopt_ro: assert property (opt_loaded_ff && !key_match |=> $stable(secopt_ff))
    else $error("security options changed");
  a_unlock_sec: assert property (opt_loaded_ff && key_match && key_enabled_w
    |=> ##1 !secured_ff)
    else $error("unlock did not unsecure");
  a_key_access_bit_gate: assert property (!key_enabled_w |=> $stable(key_access_bit_ff))
    else $error("key access bit written while disabled");
  a_keycfg_zero: assert property (wb_ack_ff && !$past(wb_req.we) && $past(hit_keycfg_w)
    |-> (wb_dat_ff & ~(32'h1 << FCS_KEY_ACCESS_BIT)) == 32'h0)
    else $error("configuration reserved bits nonzero");
  a_key_route: assert property (arr_req.wr && key_access_bit_ff
    |=> key_write_ff && !cmd_write_ff)
    else $error("key write routed as command");
  a_bus_ack_drop: assert property (wb_ack_ff |=> !wb_ack_ff)
    else $error("ack held for two cycles");

  c_unlock: cover property (key_match && key_enabled_w ##2 !secured_ff);
  c_div_lock: cover property (div_accept_w && !wb_req.dat[FCS_DIVLD_BIT] ##1 div_locked_ff);
  c_blocked_rd: cover property (arr_req.rd && rd_block_busy_w ##1 rd_blocked_ff);
  c_pe_pulse: cover property ($rose(pe_pulse_ff) ##[1:600] $fell(pe_pulse_ff));

endmodule : fcs_flash_ctrl

// >>> fcs_pkg.sv
// Shared constants, layouts and carriers of the flash clock, security and key block.
// Assumes one bus clock of 250 MHz and a 32-bit classic Wishbone register bus.
package fcs_pkg;

  // Register byte offsets, one aligned word each
  localparam int unsigned FCS_ADR_W = 8;
  localparam logic [7:0] FCS_OFS_CLKDIV = 8'h00;
  localparam logic [7:0] FCS_OFS_SECOPT = 8'h04;
  localparam logic [7:0] FCS_OFS_KEYCFG = 8'h08;
  localparam logic [7:0] FCS_OFS_STATUS = 8'h0C;
  localparam int unsigned FCS_REG_COUNT = 16;

  // Clock divider field layout
  localparam int unsigned FCS_DIVLD_BIT = 7;
  localparam int unsigned FCS_PRESCALE_BIT = 6;
  localparam int unsigned FCS_DIV_W = 6;
  localparam int unsigned FCS_PRESCALE_RATIO = 8;
  localparam int unsigned FCS_PRE_W = 3;

  // Security options layout and encodings
  localparam int unsigned FCS_KEY_ENABLE_LO = 6;
  localparam int unsigned FCS_SECURITY_LO = 0;
  localparam logic [1:0] FCS_KEY_ENABLE_ON = 2'h2;
  localparam logic [1:0] FCS_KEY_ENABLE_OFF_PREF = 2'h1;
  localparam logic [1:0] FCS_SECURITY_OPEN = 2'h2;
  localparam logic [1:0] FCS_SECURITY_CLOSED_PREF = 2'h1;

  // Key configuration layout
  localparam int unsigned FCS_KEY_ACCESS_BIT = 5;

  // Status word layout
  localparam int unsigned FCS_ST_SECURED = 0;
  localparam int unsigned FCS_ST_KEY_ENABLE = 1;
  localparam int unsigned FCS_ST_RANGE_OK = 2;
  localparam int unsigned FCS_ST_PULSE = 3;

  // Values after reset
  localparam logic [7:0] FCS_CLKDIV_RST = 8'h00;
  localparam logic [7:0] FCS_SECOPT_RST = {FCS_KEY_ENABLE_OFF_PREF, 4'h0, FCS_SECURITY_CLOSED_PREF};
  localparam logic [7:0] FCS_KEYCFG_RST = 8'h00;

  // Program/erase pulse window
  localparam int unsigned FCS_CLK_MHZ = 250;
  localparam int unsigned FCS_PULSE_MIN_NS = 5000;
  localparam int unsigned FCS_PULSE_MAX_NS = 6700;
  localparam int unsigned FCS_PULSE_MIN_CYC = (FCS_PULSE_MIN_NS * FCS_CLK_MHZ + 999) / 1000;
  localparam int unsigned FCS_PULSE_MAX_CYC = (FCS_PULSE_MAX_NS * FCS_CLK_MHZ) / 1000;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [FCS_ADR_W-1:0] adr;
    logic [31:0] dat;
  } fcs_wb_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [16:0] addr;
    logic [7:0] wdata;
  } fcs_arr_req_t;

  typedef enum logic [1:0] {
    FCS_PS_IDLE = 2'b00,
    FCS_PS_ARM = 2'b01,
    FCS_PS_ACTIVE = 2'b10
  } fcs_pulse_state_t;

endpackage : fcs_pkg

// >>> tb_flash_clock_security_config.sv
// Self-checking testbench of the flash clock, security and key block.
// Assumes fcs_pkg and fcs_flash_ctrl are compiled first; bus clock 250 MHz.
`timescale 1ns/10ps

module tb_flash_clock_security_config;
  import fcs_pkg::*;
  logic clk, rst, key_match, pe_start;
  fcs_wb_req_t wb_req;
  fcs_arr_req_t arr_req;
  logic [7:0] cell_data, nv_byte, rd_data_ff, wr_data_ff, wr_page_ff;
  logic [1:0] cmd_busy;
  logic wb_ack_ff, rd_valid_ff, rd_blocked_ff, cmd_write_ff, key_write_ff;
  logic divided_flash_clock_ff, pe_pulse_ff, secured_ff;
  logic [31:0] wb_dat_ff, rdat;
  logic [16:0] wr_addr_ff;
  int errors, checked, r;

  fcs_flash_ctrl dut (
    .clk(clk), .rst(rst), .wb_req(wb_req), .wb_ack_ff(wb_ack_ff), .wb_dat_ff(wb_dat_ff),
    .arr_req(arr_req), .cell_data(cell_data), .cmd_busy(cmd_busy),
    .nonvolatile_security_byte(nv_byte), .key_match(key_match), .pe_start(pe_start),
    .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff), .rd_blocked_ff(rd_blocked_ff),
    .cmd_write_ff(cmd_write_ff), .key_write_ff(key_write_ff), .wr_addr_ff(wr_addr_ff),
    .wr_data_ff(wr_data_ff), .wr_page_ff(wr_page_ff),
    .divided_flash_clock_ff(divided_flash_clock_ff), .pe_pulse_ff(pe_pulse_ff),
    .secured_ff(secured_ff)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Classic single cycle; held until ack is sampled, then one idle cycle
  task wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    wb_req <= '{1'b1, 1'b1, we, 4'hF, a, {24'h0, d}};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_ff !== 1'b1 && n < 50);
    chk({31'h0, wb_ack_ff}, 32'h1);
    rdat = wb_dat_ff;
    wb_req <= '0;
    @(posedge clk);
  endtask : wb

  task arr(input logic wr, input logic [16:0] a, input logic [7:0] d);
    arr_req <= '{~wr, wr, a, d};
    cell_data <= d;
    @(posedge clk);
    arr_req <= '0;
    cell_data <= ~d;
    @(posedge clk);
  endtask : arr

  // Spacing in bus cycles between two flash clock ticks
  task period(output int p);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (divided_flash_clock_ff !== 1'b1 && n < 600);
    p = 0;
    do begin
      @(posedge clk);
      p++;
    end while (divided_flash_clock_ff !== 1'b1 && p < 600);
  endtask : period

  task pulse(output int w);
    int n;
    n = 0;
    w = 0;
    pe_start <= 1'b1;
    @(posedge clk);
    pe_start <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (pe_pulse_ff !== 1'b1 && n < 600);
    while (pe_pulse_ff === 1'b1 && w < 600) begin
      @(posedge clk);
      w++;
    end
  endtask : pulse

  task keys;
    key_match <= 1'b1;
    @(posedge clk);
    key_match <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : keys

  task do_reset(input logic [7:0] nv);
    rst <= 1'b1;
    nv_byte <= nv;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : do_reset

  task t_regs;
    wb(1'b0, FCS_OFS_CLKDIV, 8'h00); chk(rdat, 32'h0);
    wb(1'b0, FCS_OFS_SECOPT, 8'h00); chk(rdat, 32'h81);
    chk({31'h0, secured_ff}, 32'h1);
    wb(1'b0, FCS_OFS_STATUS, 8'h00); chk(rdat, 32'h3);
    wb(1'b1, FCS_OFS_SECOPT, 8'hFF);
    wb(1'b0, FCS_OFS_SECOPT, 8'h00); chk(rdat, 32'h81);
    wb(1'b1, FCS_OFS_KEYCFG, 8'hFF);
    wb(1'b0, FCS_OFS_KEYCFG, 8'h00); chk(rdat, 32'h20);
    wb(1'b1, 8'h10, 8'hFF);
    wb(1'b0, 8'h10, 8'h00); chk(rdat, 32'h0);
    wb(1'b0, 8'h40, 8'h00); chk(rdat, 32'h0);
    $display("registers test done");
  endtask : t_regs

  task t_array;
    arr(1'b0, 17'h00010, 8'h5A); chk(rd_valid_ff, 1); chk(rd_data_ff, 8'hA5);
    arr(1'b1, 17'h10200, 8'h3C); chk({key_write_ff, cmd_write_ff}, 2'b10);
    chk({wr_page_ff, wr_data_ff}, 16'h813C);
    chk(wr_addr_ff, 32'h10200);
    wb(1'b1, FCS_OFS_KEYCFG, 8'h00);
    arr(1'b1, 17'h00200, 8'hC3); chk({key_write_ff, cmd_write_ff}, 2'b01);
    cmd_busy <= 2'b01;
    arr(1'b0, 17'h00020, 8'h00); chk({rd_blocked_ff, rd_valid_ff}, 2'b10);
    arr(1'b0, 17'h10020, 8'h00); chk({rd_blocked_ff, rd_valid_ff}, 2'b01);
    chk(rd_data_ff, 8'hFF);
    cmd_busy <= 2'b00;
    $display("array test done");
  endtask : t_array

  task t_divider;
    wb(1'b1, FCS_OFS_CLKDIV, 8'hC1);
    wb(1'b0, FCS_OFS_CLKDIV, 8'h00); chk(rdat, 32'hC1);
    period(r); chk(r, 16);
    wb(1'b1, FCS_OFS_CLKDIV, 8'h03);
    period(r); chk(r, 4);
    wb(1'b1, FCS_OFS_CLKDIV, 8'h3F);
    wb(1'b0, FCS_OFS_CLKDIV, 8'h00); chk(rdat, 32'h83);
    pulse(r); chk(r, 4);
    $display("divider test done");
  endtask : t_divider

  task t_unlock;
    keys;
    chk({31'h0, secured_ff}, 32'h0);
    wb(1'b0, FCS_OFS_SECOPT, 8'h00); chk(rdat, 32'h82);
    $display("unlock test done");
  endtask : t_unlock

  task t_disabled;
    do_reset(8'h03);
    chk({31'h0, secured_ff}, 32'h1);
    wb(1'b1, FCS_OFS_KEYCFG, 8'h20);
    wb(1'b0, FCS_OFS_KEYCFG, 8'h00); chk(rdat, 32'h0);
    keys;
    chk({31'h0, secured_ff}, 32'h1);
    arr(1'b1, 17'h00004, 8'h11); chk({key_write_ff, cmd_write_ff}, 2'b01);
    wb(1'b1, FCS_OFS_CLKDIV, 8'h05);
    wb(1'b1, FCS_OFS_CLKDIV, 8'h09);
    wb(1'b0, FCS_OFS_CLKDIV, 8'h00); chk(rdat, 32'h85);
    period(r); chk(r, 6);
    $display("disabled key test done");
  endtask : t_disabled

  task results;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  initial begin
    rst = 1'b1;
    wb_req = '0;
    arr_req = '0;
    cell_data = 8'h00;
    cmd_busy = 2'b00;
    nv_byte = 8'h81;
    key_match = 1'b0;
    pe_start = 1'b0;
    errors = 0;
    checked = 0;
    do_reset(8'h81);
    t_regs;
    t_array;
    t_divider;
    t_unlock;
    t_disabled;
    results;
  end

  // Whole run needs a few hundred cycles
  initial begin
    #200000;
    errors++;
    results;
  end
endmodule : tb_flash_clock_security_config
